// ---- rtl/serial_channel_pair.sv ----
// Function
// - software enables unit before configuring it
// - bit clock divides operation clock by 2*(divider+1)
// - idle transmit line follows serial output bit
// - drive only with output enable and port
// - start bit write enables channel status
// - data byte write starts transmit frame
// - output level select inverts transmitted frame bits; the idle level still follows the serial output bit
// - interrupt source select changeable while running
// - write while buffer full overwrites pending byte
// - unit clock stop clears enables, frames and flags; settings are kept
// - software programs both channel mode registers
// - receive interrupt only at transfer end
// - separate error flags and error interrupt
// - seven or eight data bits
// - divider field must be two or more
// - none, zero, even, odd parity check
module serial_channel_pair
  import serial_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic tx_irq_out,
  output logic receive_done_irq_out,
  output logic receive_error_irq_out,
  serial_link_if.device link
);
  typedef struct packed {
    logic unit_en;
    logic [PS_W-1:0] ps;
    logic tx_md;
    logic rx_md;
    logic [FMT_W-1:0] fmt;
    logic [DIV_W-1:0] tx_div;
    logic [DIV_W-1:0] rx_div;
    logic [OUT_W-1:0] outc;
    logic tx_en;
    logic rx_en;
    logic [7:0] tx_buf;
    logic tx_bff;
    logic [7:0] tx_sh;
    frame_t tx_st;
    logic [2:0] tx_idx;
    logic tx_stop2nd;
    frame_t rx_st;
    logic [2:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic [7:0] rx_data;
    logic rx_full;
    logic fef;
    logic pef;
    logic ovf;
    logic a_wr;
    logic a_rd;
    logic [ADDR_W-1:0] a_ofs;
    logic hready;
    logic [31:0] hrdata;
    logic tx_pin;
    logic tx_oe;
    logic tx_irq;
    logic rx_irq;
    logic err_irq;
  } chan_t;

  chan_t r;
  chan_t next_r;
  logic rx_meta;
  logic rx_sync;
  logic rx_line;
  logic inv;
  logic len8;
  logic msb;
  parity_t par;
  logic [PERIOD_W-1:0] tx_period;
  logic [PERIOD_W-1:0] rx_period;
  logic tx_tick;
  logic rx_tick;
  logic tx_go;
  logic rx_go;
  logic wr_tx_data;
  logic [31:0] rd_val;

  assign inv = r.outc[OUT_INV];
  assign len8 = r.fmt[FMT_LEN8];
  assign msb = r.fmt[FMT_MSB];
  assign par = parity_t'(r.fmt[FMT_PAR_HI:FMT_PAR_LO]);
  assign tx_period = bit_period(r.ps, r.tx_div);
  assign rx_period = bit_period(r.ps, r.rx_div);
  assign rx_line = rx_sync ^ inv;
  assign tx_go = r.tx_en && (r.tx_st == F_IDLE) && r.tx_bff;
  assign rx_go = r.rx_en && (r.rx_st == F_IDLE) && !rx_line;
  assign wr_tx_data = r.a_wr && r.unit_en && r.tx_en && (r.a_ofs == OFS_TX_DATA);

  // divider below two exceeds the sampling margin; the logic still runs but is not guaranteed
  bit_timer tx_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .restart_in(tx_go),
    .load_in(tx_period - PERIOD_W'(1)),
    .period_in(tx_period),
    .tick_out(tx_tick)
  );

  bit_timer rx_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .restart_in(rx_go),
    .load_in(rx_period >> 1),
    .period_in(rx_period),
    .tick_out(rx_tick)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (r.a_ofs)
      OFS_UNIT: rd_val = 32'(r.unit_en);
      OFS_PRESCALE: rd_val = 32'(r.ps);
      OFS_TX_MODE: rd_val = 32'(r.tx_md);
      OFS_RX_MODE: rd_val = 32'(r.rx_md);
      OFS_FORMAT: rd_val = 32'(r.fmt);
      OFS_TX_DATA: rd_val = 32'({r.tx_div, 1'b0, r.tx_buf});
      OFS_RX_DATA: rd_val = 32'({r.rx_div, 1'b0, r.rx_data});
      OFS_OUTPUT: rd_val = 32'(r.outc);
      OFS_START: rd_val = 32'({r.rx_en, r.tx_en});
      OFS_STATUS: rd_val = 32'({r.ovf, r.pef, r.fef, r.rx_full, r.tx_st != F_IDLE, r.tx_bff});
      default: rd_val = 32'h00000000;
    endcase
  end

  always_comb begin
    next_r = r;
    next_r.tx_irq = 1'b0;
    next_r.rx_irq = 1'b0;
    next_r.err_irq = 1'b0;
    next_r.a_wr = 1'b0;
    // reads take one wait state so that hrdata comes from a flop
    if (r.a_rd) begin
      next_r.a_rd = 1'b0;
      next_r.hready = 1'b1;
      next_r.hrdata = rd_val;
      if (r.a_ofs == OFS_RX_DATA) next_r.rx_full = 1'b0;
    end
    if (hsel_in && hready_in && htrans_in[HTRANS_ACTIVE]) begin
      next_r.a_wr = hwrite_in;
      next_r.a_rd = !hwrite_in;
      next_r.a_ofs = haddr_in[ADDR_W-1:0];
      if (!hwrite_in) next_r.hready = 1'b0;
    end
    if (r.a_wr) begin
      if (r.a_ofs == OFS_UNIT) begin
        next_r.unit_en = hwdata_in[EN_BIT];
      end else if (r.unit_en) begin
        case (r.a_ofs)
          OFS_PRESCALE: next_r.ps = hwdata_in[PS_W-1:0];
          OFS_TX_MODE: next_r.tx_md = hwdata_in[MD_BIT];
          OFS_RX_MODE: next_r.rx_md = hwdata_in[MD_BIT];
          OFS_FORMAT: next_r.fmt = hwdata_in[FMT_W-1:0];
          OFS_TX_DATA: begin
            next_r.tx_div = hwdata_in[DIV_HI:DIV_LO];
            if (r.tx_en) begin
              next_r.tx_buf = hwdata_in[BYTE_HI:0];
              next_r.tx_bff = 1'b1;
            end
          end
          OFS_RX_DATA: next_r.rx_div = hwdata_in[DIV_HI:DIV_LO];
          OFS_OUTPUT: next_r.outc = hwdata_in[OUT_W-1:0];
          OFS_START: begin
            if (hwdata_in[START_TX]) next_r.tx_en = 1'b1;
            if (hwdata_in[START_RX]) next_r.rx_en = 1'b1;
            if (hwdata_in[STOP_TX]) next_r.tx_en = 1'b0;
            if (hwdata_in[STOP_RX]) next_r.rx_en = 1'b0;
          end
          OFS_STATUS: begin
            if (hwdata_in[ST_FEF]) next_r.fef = 1'b0;
            if (hwdata_in[ST_PEF]) next_r.pef = 1'b0;
            if (hwdata_in[ST_OVF]) next_r.ovf = 1'b0;
          end
          default: ;
        endcase
      end
    end
    //////////////////////////////////////////////////////////////////////////////
    case (r.tx_st)
      F_IDLE: begin
        next_r.tx_pin = r.outc[OUT_SO];
        if (tx_go) begin
          next_r.tx_sh = r.tx_buf;
          next_r.tx_bff = wr_tx_data;
          next_r.tx_st = F_START;
          next_r.tx_pin = inv;
          if (r.tx_md) next_r.tx_irq = 1'b1;
        end
      end
      F_START: if (tx_tick) begin
        next_r.tx_st = F_DATA;
        next_r.tx_idx = '0;
        next_r.tx_pin = r.tx_sh[bit_index('0, len8, msb)] ^ inv;
      end
      F_DATA: if (tx_tick) begin
        if (r.tx_idx == last_index(len8)) begin
          next_r.tx_st = (par == PAR_NONE) ? F_STOP : F_PAR;
          next_r.tx_stop2nd = 1'b0;
          next_r.tx_pin = ((par == PAR_NONE) ? 1'b1 : parity_bit(par, r.tx_sh, len8)) ^ inv;
        end else begin
          next_r.tx_idx = r.tx_idx + 3'h1;
          next_r.tx_pin = r.tx_sh[bit_index(r.tx_idx + 3'h1, len8, msb)] ^ inv;
        end
      end
      F_PAR: if (tx_tick) begin
        next_r.tx_st = F_STOP;
        next_r.tx_pin = !inv;
      end
      F_STOP: if (tx_tick) begin
        if (r.fmt[FMT_STOP2] && !r.tx_stop2nd) begin
          next_r.tx_stop2nd = 1'b1;
        end else begin
          next_r.tx_st = F_IDLE;
          next_r.tx_pin = r.outc[OUT_SO];
          if (!r.tx_md) next_r.tx_irq = 1'b1;
        end
      end
      default: next_r.tx_st = F_IDLE;
    endcase
    next_r.tx_oe = r.outc[OUT_OE] && r.outc[OUT_PORT];
    //////////////////////////////////////////////////////////////////////////////
    case (r.rx_st)
      F_IDLE: if (rx_go) next_r.rx_st = F_START;
      F_START: if (rx_tick) begin
        // a start bit gone by mid-bit is a glitch, not a frame
        next_r.rx_st = rx_line ? F_IDLE : F_DATA;
        next_r.rx_idx = '0;
        next_r.rx_sh = '0;
        next_r.rx_perr = 1'b0;
      end
      F_DATA: if (rx_tick) begin
        next_r.rx_sh[bit_index(r.rx_idx, len8, msb)] = rx_line;
        next_r.rx_idx = r.rx_idx + 3'h1;
        if (r.rx_idx == last_index(len8)) begin
          next_r.rx_st = (par == PAR_NONE) ? F_STOP : F_PAR;
        end
      end
      F_PAR: if (rx_tick) begin
        next_r.rx_perr = rx_line != parity_bit(par, r.rx_sh, len8);
        next_r.rx_st = F_STOP;
      end
      F_STOP: if (rx_tick) begin
        next_r.rx_st = F_IDLE;
        next_r.rx_data = r.rx_sh;
        // judged before the new char marks full, so a read this cycle avoids overrun
        if (!rx_line || r.rx_perr || next_r.rx_full) begin
          next_r.err_irq = 1'b1;
        end
        if (next_r.rx_full) next_r.ovf = 1'b1;
        next_r.rx_full = 1'b1;
        if (!rx_line) next_r.fef = 1'b1;
        if (r.rx_perr) next_r.pef = 1'b1;
        next_r.rx_irq = 1'b1;
      end
      default: next_r.rx_st = F_IDLE;
    endcase
    // unit switched off drops enables, frame states and flags; settings stay, so a restart needs only start again
    if (!r.unit_en) begin
      next_r.tx_en = 1'b0;
      next_r.rx_en = 1'b0;
      next_r.tx_st = F_IDLE;
      next_r.rx_st = F_IDLE;
      next_r.tx_bff = 1'b0;
      next_r.rx_full = 1'b0;
      next_r.fef = 1'b0;
      next_r.pef = 1'b0;
      next_r.ovf = 1'b0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
      r.hready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= link.rem_tx;
      rx_sync <= rx_meta;
    end
  end

  assign hrdata_out = r.hrdata;
  assign hreadyout_out = r.hready;
  assign hresp_out = 1'b0;
  assign tx_irq_out = r.tx_irq;
  assign receive_done_irq_out = r.rx_irq;
  assign receive_error_irq_out = r.err_irq;
  assign link.dev_tx = r.tx_pin;
  assign link.dev_tx_oe = r.tx_oe;
endmodule

// ---- rtl/serial_pkg.sv ----
package serial_pkg;
  localparam int PERIOD_W = 24;
  localparam int PS_W = 4;
  localparam int DIV_W = 7;
  localparam int DIV_LO = 9;
  localparam int DIV_HI = 15;
  localparam int BYTE_HI = 7;
  localparam int HTRANS_ACTIVE = 1;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_UNIT = 8'h00;
  localparam logic [7:0] OFS_PRESCALE = 8'h04;
  localparam logic [7:0] OFS_TX_MODE = 8'h08;
  localparam logic [7:0] OFS_RX_MODE = 8'h0C;
  localparam logic [7:0] OFS_FORMAT = 8'h10;
  localparam logic [7:0] OFS_TX_DATA = 8'h14;
  localparam logic [7:0] OFS_RX_DATA = 8'h18;
  localparam logic [7:0] OFS_OUTPUT = 8'h1C;
  localparam logic [7:0] OFS_START = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam int EN_BIT = 0;
  localparam int MD_BIT = 0;
  localparam int FMT_PAR_LO = 0;
  localparam int FMT_PAR_HI = 1;
  localparam int FMT_LEN8 = 2;
  localparam int FMT_MSB = 3;
  localparam int FMT_STOP2 = 4;
  localparam int FMT_W = 5;
  localparam int OUT_SO = 0;
  localparam int OUT_OE = 1;
  localparam int OUT_INV = 2;
  localparam int OUT_PORT = 3;
  localparam int OUT_W = 4;
  localparam int START_TX = 0;
  localparam int START_RX = 1;
  localparam int STOP_TX = 2;
  localparam int STOP_RX = 3;
  localparam int ST_TX_BFF = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_RX_FULL = 2;
  localparam int ST_FEF = 3;
  localparam int ST_PEF = 4;
  localparam int ST_OVF = 5;
  localparam logic [2:0] LAST_BIT7 = 3'h6;
  localparam logic [2:0] LAST_BIT8 = 3'h7;
  localparam logic [PERIOD_W-1:0] PERIOD_OFFSET = 24'h000002;
  typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_EVEN, PAR_ODD} parity_t;
  typedef enum logic [2:0] {F_IDLE, F_START, F_DATA, F_PAR, F_STOP} frame_t;

  // core clocks per bit: 2*(div+1) operation clocks, operation clock = core / 2^ps
  function automatic logic [PERIOD_W-1:0] bit_period(input logic [PS_W-1:0] ps,
                                                     input logic [DIV_W-1:0] div);
    logic [PERIOD_W-1:0] base;
    base = {{(PERIOD_W-DIV_W-1){1'b0}}, div, 1'b0} + PERIOD_OFFSET;
    return base << ps;
  endfunction

  function automatic logic [2:0] last_index(input logic len8);
    return len8 ? LAST_BIT8 : LAST_BIT7;
  endfunction

  function automatic logic [2:0] bit_index(input logic [2:0] idx, input logic len8,
                                           input logic msb);
    return msb ? last_index(len8) - idx : idx;
  endfunction

  function automatic logic parity_bit(input parity_t p, input logic [7:0] d, input logic len8);
    logic [7:0] m;
    m = len8 ? d : {1'b0, d[6:0]};
    case (p)
      PAR_EVEN: return ^m;
      PAR_ODD: return ~^m;
      default: return 1'b0;
    endcase
  endfunction
endpackage

// ---- rtl/serial_link_if.sv ----
interface serial_link_if;
  logic dev_tx;
  logic dev_tx_oe;
  logic rem_tx;
  modport device (output dev_tx, output dev_tx_oe, input rem_tx);
  modport remote (input dev_tx, input dev_tx_oe, output rem_tx);
endinterface

// ---- rtl/bit_timer.sv ----
module bit_timer
  import serial_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic [PERIOD_W-1:0] load_in,
  input wire logic [PERIOD_W-1:0] period_in,
  output logic tick_out
);
  logic [PERIOD_W-1:0] cnt;
  logic [PERIOD_W-1:0] next_cnt;

  // first tick after load_in+1 edges, then one every period_in edges
  always_comb begin
    tick_out = (cnt == '0) && !restart_in;
    if (restart_in) begin
      next_cnt = load_in;
    end else if (cnt == '0) begin
      next_cnt = period_in - PERIOD_W'(1);
    end else begin
      next_cnt = cnt - PERIOD_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ---- rtl/serial_remote_end.sv ----
module serial_remote_end
  import serial_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [PERIOD_W-1:0] period_in,
  input wire logic len8_in,
  input wire logic [1:0] parity_in,
  input wire logic msb_first_in,
  input wire logic two_stop_in,
  input wire logic invert_in,
  input wire logic [7:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  output logic rx_parity_err_out,
  output logic rx_frame_err_out,
  serial_link_if.remote link
);
  typedef struct packed {
    frame_t tx_st;
    logic [2:0] tx_idx;
    logic tx_stop2nd;
    logic [7:0] tx_sh;
    logic tx_pin;
    logic tx_ready;
    frame_t rx_st;
    logic [2:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_perr;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_pe;
    logic rx_fe;
  } rem_t;

  rem_t r;
  rem_t next_r;
  logic rx_meta;
  logic rx_sync;
  logic rx_raw;
  logic rx_line;
  logic tx_tick;
  logic rx_tick;
  logic tx_go;
  logic rx_go;
  parity_t par;

  assign par = parity_t'(parity_in);
  // an undriven line floats to its idle level
  assign rx_raw = link.dev_tx_oe ? link.dev_tx : !invert_in;
  assign rx_line = rx_sync ^ invert_in;
  assign tx_go = tx_valid_in && r.tx_ready;
  assign rx_go = (r.rx_st == F_IDLE) && !rx_line;

  bit_timer tx_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .restart_in(tx_go),
    .load_in(period_in - PERIOD_W'(1)),
    .period_in(period_in),
    .tick_out(tx_tick)
  );

  bit_timer rx_timer (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .restart_in(rx_go),
    .load_in(period_in >> 1),
    .period_in(period_in),
    .tick_out(rx_tick)
  );

  always_comb begin
    next_r = r;
    next_r.rx_valid = 1'b0;
    case (r.tx_st)
      F_IDLE: begin
        next_r.tx_pin = !invert_in;
        if (tx_go) begin
          next_r.tx_sh = tx_data_in;
          next_r.tx_st = F_START;
          next_r.tx_pin = invert_in;
        end
      end
      F_START: if (tx_tick) begin
        next_r.tx_st = F_DATA;
        next_r.tx_idx = '0;
        next_r.tx_pin = r.tx_sh[bit_index('0, len8_in, msb_first_in)] ^ invert_in;
      end
      F_DATA: if (tx_tick) begin
        if (r.tx_idx == last_index(len8_in)) begin
          next_r.tx_st = (par == PAR_NONE) ? F_STOP : F_PAR;
          next_r.tx_stop2nd = 1'b0;
          next_r.tx_pin = ((par == PAR_NONE) ? 1'b1 : parity_bit(par, r.tx_sh, len8_in))
                          ^ invert_in;
        end else begin
          next_r.tx_idx = r.tx_idx + 3'h1;
          next_r.tx_pin = r.tx_sh[bit_index(r.tx_idx + 3'h1, len8_in, msb_first_in)] ^ invert_in;
        end
      end
      F_PAR: if (tx_tick) begin
        next_r.tx_st = F_STOP;
        next_r.tx_pin = !invert_in;
      end
      F_STOP: if (tx_tick) begin
        if (two_stop_in && !r.tx_stop2nd) begin
          next_r.tx_stop2nd = 1'b1;
        end else begin
          next_r.tx_st = F_IDLE;
        end
      end
      default: next_r.tx_st = F_IDLE;
    endcase
    next_r.tx_ready = (next_r.tx_st == F_IDLE) && !tx_go;
    case (r.rx_st)
      F_IDLE: if (rx_go) next_r.rx_st = F_START;
      F_START: if (rx_tick) begin
        next_r.rx_st = rx_line ? F_IDLE : F_DATA;
        next_r.rx_idx = '0;
        next_r.rx_sh = '0;
        next_r.rx_perr = 1'b0;
      end
      F_DATA: if (rx_tick) begin
        next_r.rx_sh[bit_index(r.rx_idx, len8_in, msb_first_in)] = rx_line;
        next_r.rx_idx = r.rx_idx + 3'h1;
        if (r.rx_idx == last_index(len8_in)) begin
          next_r.rx_st = (par == PAR_NONE) ? F_STOP : F_PAR;
        end
      end
      F_PAR: if (rx_tick) begin
        next_r.rx_perr = rx_line != parity_bit(par, r.rx_sh, len8_in);
        next_r.rx_st = F_STOP;
      end
      F_STOP: if (rx_tick) begin
        next_r.rx_st = F_IDLE;
        next_r.rx_data = r.rx_sh;
        next_r.rx_valid = 1'b1;
        next_r.rx_pe = r.rx_perr;
        next_r.rx_fe = !rx_line;
      end
      default: next_r.rx_st = F_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      r <= '0;
      r.tx_pin <= 1'b1;
      r.tx_ready <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
    end else begin
      rx_meta <= rx_raw;
      rx_sync <= rx_meta;
    end
  end

  assign link.rem_tx = r.tx_pin;
  assign tx_ready_out = r.tx_ready;
  assign rx_data_out = r.rx_data;
  assign rx_valid_out = r.rx_valid;
  assign rx_parity_err_out = r.rx_pe;
  assign rx_frame_err_out = r.rx_fe;
endmodule

// ---- dv/serial_link_props.sv ----
module serial_link_props (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic dev_tx,
  input wire logic dev_tx_oe,
  input wire logic rem_tx
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in);
  endclocking

  ////////////////////////////////////////////////////////////////////////////////
  // the two checks that run with reset high have no disable; the two wake checks after reset fall use one
  AST_RESET_LINE: assert property (rst_in |=> !dev_tx_oe && !dev_tx)
    else $error("transmit line not quiet after reset");
  AST_REM_IDLE: assert property (rst_in |=> rem_tx)
    else $error("remote line not idle high after reset");
  AST_WAKE_QUIET: assert property (disable iff (rst_in)
    $fell(rst_in) |-> !dev_tx_oe ##1 !dev_tx_oe)
    else $error("output enabled before any register write");
  AST_REM_QUIET: assert property (disable iff (rst_in) $fell(rst_in) |-> rem_tx [*3])
    else $error("remote line moved right after reset");

  ////////////////////////////////////////////////////////////////////////////////
  // bit time is six clocks in the bench (ps 0, divider 2)
  AST_TX_BIT_HOLD: assert property (disable iff (rst_in)
    dev_tx_oe && $stable(dev_tx_oe) && $changed(dev_tx) |=> $stable(dev_tx) [*5])
    else $error("transmit bit shorter than one bit time");
  AST_OE_SETTLE: assert property (disable iff (rst_in)
    $changed(dev_tx_oe) |=> $stable(dev_tx_oe))
    else $error("output enable toggled twice in two cycles");
  AST_REM_BIT_HOLD: assert property (disable iff (rst_in)
    $changed(rem_tx) |=> $stable(rem_tx) [*5])
    else $error("remote bit shorter than one bit time");
  AST_REM_FRAME_END: assert property (disable iff (rst_in)
    $fell(rem_tx) |-> ##[1:72] rem_tx)
    else $error("remote frame never reached its stop level");

  COV_TX_FRAME: cover property (disable iff (rst_in) dev_tx_oe && $fell(dev_tx));
  COV_REM_FRAME: cover property (disable iff (rst_in) $fell(rem_tx));
  COV_OE_ON: cover property (disable iff (rst_in) $rose(dev_tx_oe));
endmodule

// ---- dv/async_serial_channel_pair_tb.sv ----
module async_serial_channel_pair_tb;
  import serial_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, bq, m;
  logic hready, hresp, txi, rdi, rei, tx_ready, rx_valid, rx_perr, rx_ferr;
  logic r_len8 = 1'b1;
  logic r_msb = 1'b0;
  logic tx_valid = 1'b0;
  logic [1:0] r_par = 2'h0;
  logic [7:0] tx_data = 8'h0;
  logic [7:0] rx_data;
  int cnt[4] = '{default: 0};
  int bad_count = 0;
  int checks_done = 0;
  int n, t, e, k;
  logic [4:0] fm[6] = '{5'h04, 5'h10, 5'h05, 5'h06, 5'h0F, 5'h03};
  logic [7:0] ch[6] = '{8'hA5, 8'h3C, 8'h81, 8'h7E, 8'h96, 8'h4B};
  logic [7:0] ef[2] = '{8'h06, 8'h04};
  logic [1:0] ep[2] = '{2'h3, 2'h1};
  logic [7:0] ec[2] = '{8'h33, 8'h00};
  logic [7:0] ex[2] = '{8'h10, 8'h08};
  logic [3:0] ov[3] = '{4'h3, 4'h9, 4'hB};

  serial_link_if serial_link_if_inst ();
  wire logic ltx = serial_link_if_inst.dev_tx;
  wire logic loe = serial_link_if_inst.dev_tx_oe;
  serial_channel_pair serial_channel_pair_inst (
    .core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
    .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp), .tx_irq_out(txi),
    .receive_done_irq_out(rdi), .receive_error_irq_out(rei), .link(serial_link_if_inst.device));
  serial_remote_end serial_remote_end_inst (
    .core_clk_in(clk), .rst_in(rst), .period_in(24'h000006), .len8_in(r_len8),
    .parity_in(r_par), .msb_first_in(r_msb), .two_stop_in(1'b0), .invert_in(1'b0),
    .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_parity_err_out(rx_perr),
    .rx_frame_err_out(rx_ferr), .link(serial_link_if_inst.remote));
  serial_link_props serial_link_props_inst (
    .core_clk_in(clk), .rst_in(rst), .dev_tx(ltx), .dev_tx_oe(loe),
    .rem_tx(serial_link_if_inst.rem_tx));

  ////////////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  // one-cycle pulses are counted, so waits never miss them
  always @(posedge clk) begin
    if (rx_valid === 1'b1) cnt[0]++;
    if (rdi === 1'b1) cnt[1]++;
    if (rei === 1'b1) cnt[2]++;
    if (txi === 1'b1) cnt[3]++;
  end

  task give_verdict;
    $display("mismatches %0d checks %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tmo(input string nm);
    bad_count++;
    $display("BAD %s expected done seen timeout", nm);
    give_verdict;
  endtask

  // ready is looked at mid-cycle, so the deciding edge is never raced
  task waitrdy(input logic s);
    int i;
    logic r;
    i = 0;
    do begin
      @(negedge clk);
      r = s ? tx_ready : hready;
      bq = hrdata;
      @(posedge clk);
      i++;
    end while (r !== 1'b1 && i < 3000);
    if (r !== 1'b1) tmo("handshake");
  endtask

  task waitc(input int s, input int tg);
    int i;
    for (i = 0; i < 3000 && cnt[s] < tg; i++) @(negedge clk);
    if (cnt[s] < tg) tmo("event");
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    waitrdy(1'b0);
    htrans <= 2'h0;
    hwdata <= d;
    waitrdy(1'b0);
    q = bq;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task rsend(input logic [7:0] c);
    @(posedge clk);
    tx_data <= c;
    tx_valid <= 1'b1;
    waitrdy(1'b1);
    tx_valid <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wr(OFS_OUTPUT, 32'hB);
    xfer(1'b0, OFS_OUTPUT, 0);
    chk("locked_out", q, 0);
    chk("hresp", {31'h0, hresp}, 0);
    xfer(1'b0, 8'h3C, 0);
    chk("unmapped", q, 0);
    wr(OFS_UNIT, 32'h1);
    wr(OFS_PRESCALE, 32'h0);
    wr(OFS_TX_MODE, 32'h0);
    wr(OFS_RX_MODE, 32'h1);
    wr(OFS_TX_DATA, 32'h400);
    wr(OFS_RX_DATA, 32'h400);
    for (k = 0; k < 3; k++) begin
      wr(OFS_OUTPUT, {28'h0, ov[k]});
      // pin enable follows the stored register one clock later
      repeat (2) @(negedge clk);
      chk("oe", {31'h0, loe}, {31'h0, ov[k] == 4'hB});
    end
    chk("idle", {31'h0, ltx}, 1);
    wr(OFS_START, 32'h3);
    xfer(1'b0, OFS_START, 0);
    chk("enabled", q & 32'h3, 32'h3);
    for (int i = 0; i < 6; i++) begin
      m = fm[i][FMT_LEN8] ? 32'hFF : 32'h7F;
      wr(OFS_FORMAT, {27'h0, fm[i]});
      r_len8 <= fm[i][FMT_LEN8];
      r_par <= fm[i][FMT_PAR_HI:FMT_PAR_LO];
      r_msb <= fm[i][FMT_MSB];
      n = cnt[0];
      wr(OFS_TX_DATA, {24'h000004, ch[i]});
      waitc(0, n + 1);
      chk("tx_char", {24'h0, rx_data} & m, {24'h0, ch[i]} & m);
      chk("tx_par", {31'h0, rx_perr}, 0);
      chk("tx_stop", {31'h0, rx_ferr}, 0);
      n = cnt[1];
      rsend(~ch[i]);
      waitc(1, n + 1);
      xfer(1'b0, OFS_RX_DATA, 0);
      chk("rx_char", q & m, {24'h0, ~ch[i]} & m);
      xfer(1'b0, OFS_STATUS, 0);
      chk("rx_flags", q & 32'h38, 0);
    end
    wr(OFS_FORMAT, 32'h4);
    r_len8 <= 1'b1;
    r_par <= 2'h0;
    r_msb <= 1'b0;
    n = cnt[0];
    t = cnt[3];
    wr(OFS_TX_DATA, 32'h411);
    wr(OFS_TX_DATA, 32'h422);
    wr(OFS_TX_DATA, 32'h433);
    xfer(1'b0, OFS_STATUS, 0);
    chk("full_busy", q & 32'h3, 32'h3);
    waitc(0, n + 1);
    chk("first", {24'h0, rx_data}, 32'h11);
    waitc(0, n + 2);
    chk("replaced", {24'h0, rx_data}, 32'h33);
    repeat (80) @(negedge clk);
    chk("frames", cnt[0], n + 2);
    chk("end_irqs", cnt[3], t + 2);
    wr(OFS_TX_MODE, 32'h1);
    t = cnt[3];
    wr(OFS_TX_DATA, 32'h455);
    repeat (3) @(negedge clk);
    chk("empty_irq", cnt[3], t + 1);
    repeat (80) @(negedge clk);
    chk("no_end_irq", cnt[3], t + 1);
    wr(OFS_TX_MODE, 32'h0);
    e = cnt[2];
    n = cnt[1];
    rsend(8'h11);
    waitc(1, n + 1);
    rsend(8'h22);
    waitc(1, n + 2);
    chk("ovf_irq", cnt[2], e + 1);
    xfer(1'b0, OFS_STATUS, 0);
    chk("ovf", q & 32'h38, 32'h20);
    xfer(1'b0, OFS_RX_DATA, 0);
    chk("ovf_char", q & 32'hFF, 32'h22);
    wr(OFS_STATUS, 32'h38);
    xfer(1'b0, OFS_STATUS, 0);
    chk("cleared", q & 32'h3F, 0);
    for (int i = 0; i < 2; i++) begin
      wr(OFS_FORMAT, {24'h0, ef[i]});
      r_par <= ep[i];
      e = cnt[2];
      n = cnt[1];
      rsend(ec[i]);
      waitc(1, n + 1);
      chk("err_irq", cnt[2], e + 1);
      xfer(1'b0, OFS_STATUS, 0);
      chk("err_flag", q & 32'h38, {24'h0, ex[i]});
      xfer(1'b0, OFS_RX_DATA, 0);
      wr(OFS_STATUS, 32'h38);
    end
    r_par <= 2'h0;
    wr(OFS_FORMAT, 32'h4);
    // inverted check watches the pin, since the remote end idles high only
    wr(OFS_START, 32'h8);
    wr(OFS_OUTPUT, 32'hE);
    repeat (8) @(negedge clk);
    chk("inv_idle", {31'h0, ltx}, 0);
    wr(OFS_TX_DATA, 32'h401);
    for (k = 0; k < 20 && ltx !== 1'b1; k++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk("inv_start", {31'h0, ltx}, 1);
    repeat (6) @(negedge clk);
    chk("inv_bit0", {31'h0, ltx}, 0);
    repeat (6) @(negedge clk);
    chk("inv_bit1", {31'h0, ltx}, 1);
    repeat (80) @(negedge clk);
    wr(OFS_OUTPUT, 32'hB);
    repeat (80) @(negedge clk);
    wr(OFS_UNIT, 32'h0);
    xfer(1'b0, OFS_START, 0);
    chk("unit_off", q, 0);
    give_verdict;
  end
endmodule
